// ==== hw/outdiv_pkg.sv ====
// Package for the first output-pair divider configuration block.
// Assumes an APB slave at 32-bit data with register index times four as byte address.
package outdiv_pkg;

  // ==========================================================================
  // Register indices (byte address is index times four)
  localparam int          ADDR_W      = 12;
  localparam logic [9:0]  IDX_PHASE   = 10'h191;
  localparam logic [9:0]  IDX_ROUTE   = 10'h192;
  localparam logic [9:0]  IDX_STATUS  = 10'h193;
  localparam logic [9:0]  IDX_SRCSEL  = 10'h1e1;

  // ==========================================================================
  // Field positions, phase and level register
  localparam int          BIT_BYPASS  = 7;
  localparam int          BIT_NOSYNC  = 6;
  localparam int          BIT_FORCE   = 5;
  localparam int          BIT_START   = 4;
  localparam int          PHASE_MSB   = 3;
  localparam int          PHASE_LSB   = 0;

  // Field positions, route and duty register
  localparam int          BIT_DIRECT  = 1;
  localparam int          BIT_DUTY_CORRECTION_DISABLE  = 0;

  // Field positions, status register
  localparam int          ST_DIVOUT   = 0;
  localparam int          ST_HOLD     = 1;
  localparam int          ST_DIRECT   = 2;
  localparam int          ST_CNT_LSB  = 4;

  // ==========================================================================
  // Distribution source-select codes, field [1:0]
  localparam logic [1:0]  SRC_EXT     = 2'h0;
  localparam logic [1:0]  SRC_NONE    = 2'h1;
  localparam logic [1:0]  SRC_OSC     = 2'h2;

  // ==========================================================================
  // Reset values
  localparam logic [7:0]  PHASE_RST   = 8'h00;
  localparam logic [7:0]  ROUTE_RST   = 8'h00;
  localparam logic [7:0]  SRCSEL_RST  = 8'h00;

  typedef enum logic [1:0] {DIV_HOLD, DIV_DELAY, DIV_RUN} div_state_t;

endpackage : outdiv_pkg

// ==== hw/output_divider_phase_route_cfg.sv ====
// First output-pair divider with its configuration registers on APB.
// Assumes oscillator, external clock and sync arrive as pins slower than clk_sys/4.
//
// Added by the designer: the APB slave port.
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// - Divider output starts low when start-level bit is 0, high when 1.
// - Four-bit phase offset field delays the divider; it resets to zero.
// - In forced mode with force-high set, bypass clear and no direct route active, output holds constant high.
// - With direct-route, bypass and sync-ignore bits all clear, both outputs follow the divider.
// - Direct route with source select 10b sends oscillator straight to outputs.
// - Direct route with source select 00b sends external clock to outputs.
// - Source select 01b makes direct-route bit ineffective; the divider path (divider, bypass or force level) feeds outputs.
// - Duty correction on when disable bit is 0, off when it is 1.
// - Force-high bit is ignored while the divider bypass bit is set.
module output_divider_phase_route_cfg
  import outdiv_pkg::*;
(
  input  wire logic              clk_sys,
  input  wire logic              rst_n,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output var  logic [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              internalOscillator,
  input  wire logic              extClockIn,
  input  wire logic              syncIn,
  output var  logic              firstOutput,
  output var  logic              secondOutput,
  output logic                   dutyCorrectEn
);

  // ==========================================================================
  // Pin synchronisers: bit 0 oscillator, bit 1 external clock, bit 2 sync
  logic [2:0] pinMeta;
  logic [2:0] pinSync;
  logic [2:0] pinPrev;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pinMeta <= 3'h0;
      pinSync <= 3'h0;
      pinPrev <= 3'h0;
    end else begin
      pinMeta <= {syncIn, extClockIn, internalOscillator};
      pinSync <= pinMeta;
      pinPrev <= pinSync;
    end
  end

  // ==========================================================================
  // APB register file
  logic [7:0]  phaseReg;
  logic [7:0]  routeReg;
  logic [7:0]  srcSelReg;
  logic [7:0]  next_phaseReg;
  logic [7:0]  next_routeReg;
  logic [7:0]  next_srcSelReg;
  logic [31:0] next_prdata;
  logic [7:0]  statusVal;
  logic        addrHit;
  logic        doWrite;
  logic        setupPhase;
  logic [9:0]  regIdx;

  assign regIdx     = paddr[ADDR_W-1:2];
  assign setupPhase = psel & ~penable;
  assign doWrite    = psel & penable & pwrite & addrHit & pstrb[0];

  always_comb begin
    addrHit = (paddr[1:0] == 2'h0) &&
              ((regIdx == IDX_PHASE) || (regIdx == IDX_ROUTE) ||
               (regIdx == IDX_STATUS) || (regIdx == IDX_SRCSEL));
  end

  // Zero wait states; read data is loaded in setup so it comes from a flop
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~addrHit;

  always_comb begin
    next_phaseReg  = phaseReg;
    next_routeReg  = routeReg;
    next_srcSelReg = srcSelReg;
    next_prdata    = prdata;
    if (doWrite) begin
      case (regIdx)
        IDX_PHASE:  next_phaseReg  = pwdata[7:0];
        IDX_ROUTE:  next_routeReg  = {6'h0, pwdata[1:0]};
        IDX_SRCSEL: next_srcSelReg = {6'h0, pwdata[1:0]};
        default:    next_phaseReg  = phaseReg;
      endcase
    end
    // Misaligned or unmapped reads return zero alongside the error
    if (setupPhase && !addrHit) begin
      next_prdata = 32'h0;
    end else if (setupPhase) begin
      case (regIdx)
        IDX_PHASE:  next_prdata = {24'h0, phaseReg};
        IDX_ROUTE:  next_prdata = {24'h0, routeReg};
        IDX_STATUS: next_prdata = {24'h0, statusVal};
        IDX_SRCSEL: next_prdata = {24'h0, srcSelReg};
        default:    next_prdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      phaseReg  <= PHASE_RST;
      routeReg  <= ROUTE_RST;
      srcSelReg <= SRCSEL_RST;
      prdata    <= 32'h0;
    end else begin
      phaseReg  <= next_phaseReg;
      routeReg  <= next_routeReg;
      srcSelReg <= next_srcSelReg;
      prdata    <= next_prdata;
    end
  end

  // ==========================================================================
  // Field decode
  logic       bypass;
  logic       noSync;
  logic       forceHigh;
  logic       startHigh;
  logic [3:0] phaseOfs;
  logic       direct;
  logic [1:0] srcSel;
  logic       syncActive;
  logic       srcLevel;
  logic       srcEdge;

  assign bypass     = phaseReg[BIT_BYPASS];
  assign noSync     = phaseReg[BIT_NOSYNC];
  assign forceHigh  = phaseReg[BIT_FORCE];
  assign startHigh  = phaseReg[BIT_START];
  assign phaseOfs   = phaseReg[PHASE_MSB:PHASE_LSB];
  assign direct     = routeReg[BIT_DIRECT];
  assign srcSel     = srcSelReg[1:0];
  assign syncActive = pinSync[2] & ~noSync;

  // Divider runs from the external clock only when 00b selects it
  assign srcLevel = (srcSel == SRC_EXT) ? pinSync[1] : pinSync[0];
  assign srcEdge  = (srcSel == SRC_EXT) ? (pinSync[1] & ~pinPrev[1])
                                        : (pinSync[0] & ~pinPrev[0]);

  // Duty correction level goes to the analog output stage
  assign dutyCorrectEn = ~routeReg[BIT_DUTY_CORRECTION_DISABLE];

  // ==========================================================================
  // Divider core: hold in sync, count phase edges, then toggle
  div_state_t state;
  div_state_t next_state;
  logic [3:0] phaseCnt;
  logic [3:0] next_phaseCnt;
  logic       divOut;
  logic       next_divOut;

  always_comb begin
    next_state    = state;
    next_phaseCnt = phaseCnt;
    next_divOut   = divOut;
    case (state)
      DIV_HOLD: begin
        next_divOut   = startHigh;
        next_phaseCnt = phaseOfs;
        if (!syncActive) begin
          next_state = DIV_DELAY;
        end
      end
      DIV_DELAY: begin
        if (srcEdge) begin
          if (phaseCnt == 4'h0) begin
            next_divOut = ~divOut;
            next_state  = DIV_RUN;
          end else begin
            next_phaseCnt = phaseCnt - 4'h1;
          end
        end
      end
      DIV_RUN: begin
        // Toggling on source edges gives 50 % duty by construction
        if (srcEdge) begin
          next_divOut = ~divOut;
        end
      end
      default: begin
        next_state = DIV_HOLD;
      end
    endcase
    if (syncActive) begin
      next_state = DIV_HOLD;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state    <= DIV_HOLD;
      phaseCnt <= 4'h0;
      divOut   <= 1'b0;
    end else begin
      state    <= next_state;
      phaseCnt <= next_phaseCnt;
      divOut   <= next_divOut;
    end
  end

  // ==========================================================================
  // Output routing
  logic divPath;
  logic directOsc;
  logic directExt;
  logic next_out;

  assign directOsc = direct & (srcSel == SRC_OSC);
  assign directExt = direct & (srcSel == SRC_EXT);

  always_comb begin
    // Forcing needs the sync ignore bit, and bypass overrides forcing
    if (bypass) begin
      divPath = srcLevel;
    end else if (noSync) begin
      divPath = forceHigh;
    end else begin
      divPath = divOut;
    end
    if (directOsc) begin
      next_out = pinSync[0];
    end else if (directExt) begin
      next_out = pinSync[1];
    end else begin
      next_out = divPath;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      firstOutput  <= 1'b0;
      secondOutput <= 1'b0;
    end else begin
      firstOutput  <= next_out;
      secondOutput <= next_out;
    end
  end

  always_comb begin
    statusVal             = 8'h0;
    statusVal[ST_DIVOUT]  = divOut;
    statusVal[ST_HOLD]    = (state == DIV_HOLD);
    statusVal[ST_DIRECT]  = directOsc | directExt;
    statusVal[ST_CNT_LSB+3:ST_CNT_LSB] = phaseCnt;
  end

  // ==========================================================================
  // Assertions
  sequence s_release;
    state == DIV_HOLD ##1 state == DIV_DELAY;
  endsequence

  sequence s_phase_write;
    doWrite && regIdx == IDX_PHASE ##1 1'b1;
  endsequence

  a_start_level: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_release |-> divOut == $past(startHigh))
    else $error("divider did not start at the programmed level");

  a_phase_load: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_release |-> phaseCnt == $past(phaseOfs))
    else $error("phase offset not loaded on sync release");

  a_phase_count: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state == DIV_DELAY && srcEdge && phaseCnt != 4'h0 && !syncActive)
    |=> state == DIV_DELAY && phaseCnt == $past(phaseCnt) - 4'h1 && divOut == $past(divOut))
    else $error("divider toggled before phase offset elapsed");

  a_force_high: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (noSync && forceHigh && !bypass && !direct) [*2] |-> firstOutput && secondOutput)
    else $error("forced output not held high");

  a_default_route: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (!direct && !bypass && !noSync) |=> firstOutput == $past(divOut))
    else $error("outputs not driven by divider");

  a_direct_osc: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (direct && srcSel == SRC_OSC) |=> firstOutput == $past(pinSync[0]))
    else $error("oscillator not routed to outputs");

  a_direct_ext: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (direct && srcSel == SRC_EXT) |=> secondOutput == $past(pinSync[1]))
    else $error("external clock not routed to outputs");

  a_route_ignored: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (srcSel == SRC_NONE && !bypass && !noSync) |=> firstOutput == $past(divOut))
    else $error("direct route acted with source select 01b");

  a_dcc_follow: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (doWrite && regIdx == IDX_ROUTE) |=> dutyCorrectEn == !$past(pwdata[BIT_DUTY_CORRECTION_DISABLE]))
    else $error("duty correction enable does not follow write");

  a_bypass_wins: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_phase_write ##0 (bypass && !direct) |=> firstOutput == $past(srcLevel))
    else $error("force bit acted while bypassed");

endmodule : output_divider_phase_route_cfg

`default_nettype wire

// ==== tb/output_divider_phase_route_cfg_tb.sv ====
// Self-checking bench for the first output-pair divider configuration block.
// Assumes the zero-wait APB slave and 2-FF pin synchronisers of the design.
`timescale 1ns/100ps
`default_nettype none

module output_divider_phase_route_cfg_tb
  import outdiv_pkg::*;
;
  logic              clk_sys;
  logic              rst_n;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata;
  logic [3:0]        pstrb;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic              internalOscillator;
  logic              extClockIn;
  logic              syncIn;
  logic              firstOutput;
  logic              secondOutput;
  logic              dutyCorrectEn;
  int                error_cnt;
  int                cmp_count;
  logic [31:0]       rd;
  logic              err;

  output_divider_phase_route_cfg u_output_divider_phase_route_cfg (
    .clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .internalOscillator(internalOscillator), .extClockIn(extClockIn),
    .syncIn(syncIn), .firstOutput(firstOutput), .secondOutput(secondOutput),
    .dutyCorrectEn(dutyCorrectEn)
  );

  // ==========================================================================
  // Report
  task automatic test_done();
    $display("comparisons %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : test_done

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check

  // ==========================================================================
  // APB master; waits on pready with a bound since the slave sets the pace
  task automatic apbXfer(input logic wr, input logic [11:0] addr, input logic [7:0] val,
                         output logic [31:0] data, output logic slvErr);
    int n;
    @(posedge clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= addr;
    pwdata  <= {24'h000000, val};
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      error_cnt++;
      $display("unexpected at %0t: pready never came", $time);
      test_done();
    end
    data    = prdata;
    slvErr  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apbXfer

  task automatic regWr(input logic [9:0] idx, input logic [7:0] val);
    apbXfer(1'b1, {idx, 2'b00}, val, rd, err);
  endtask : regWr

  task automatic regChk(input logic [9:0] idx, input logic [7:0] exp);
    apbXfer(1'b0, {idx, 2'b00}, 8'h00, rd, err);
    check(rd, {24'h000000, exp}, "register read");
  endtask : regChk

  // Pins are driven slower than clk_sys/4 as the synchronisers require
  task automatic oscPulse();
    @(posedge clk_sys);
    internalOscillator <= 1'b1;
    repeat (4) @(posedge clk_sys);
    internalOscillator <= 1'b0;
    repeat (6) @(posedge clk_sys);
  endtask : oscPulse

  task automatic outChk(input logic exp, input string what);
    check({31'h0, firstOutput}, {31'h0, exp}, what);
    check({31'h0, secondOutput}, {31'h0, exp}, what);
  endtask : outChk

  // ==========================================================================
  // Clock and sequence
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  logic [7:0] rowPhase [7] = '{8'h60, 8'h60, 8'h60, 8'h60, 8'h40, 8'he0, 8'he0};
  logic [7:0] rowRoute [7] = '{8'h02, 8'h02, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [1:0] rowSrc   [7] = '{SRC_OSC, SRC_EXT, SRC_NONE, SRC_OSC, SRC_OSC, SRC_OSC, SRC_EXT};
  int         rowMode  [7] = '{2, 3, 1, 1, 0, 2, 3};
  logic [7:0] divSet   [4] = '{8'h13, 8'h00, 8'h1f, 8'h05};

  initial begin
    error_cnt = 0;
    cmp_count = 0;
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    pstrb = 4'hf;
    internalOscillator = 1'b0;
    extClockIn = 1'b0;
    syncIn = 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;

    check({31'h0, dutyCorrectEn}, 32'h1, "duty default");
    regChk(IDX_PHASE, PHASE_RST);
    regChk(IDX_ROUTE, ROUTE_RST);
    regChk(IDX_SRCSEL, SRCSEL_RST);
    apbXfer(1'b0, 12'h000, 8'h00, rd, err);
    check({31'h0, err}, 32'h1, "unmapped error");
    check(rd, 32'h0, "unmapped data");
    regWr(IDX_ROUTE, 8'hff);
    regChk(IDX_ROUTE, 8'h03);
    check({31'h0, dutyCorrectEn}, 32'h0, "duty off");
    regWr(IDX_ROUTE, 8'h00);
    @(posedge clk_sys);
    check({31'h0, dutyCorrectEn}, 32'h1, "duty on");
    $display("test registers done");

    // Each row: pins set opposite ways so the route shows which one feeds out
    for (int i = 0; i < 7; i++) begin
      regWr(IDX_PHASE, rowPhase[i]);
      regWr(IDX_ROUTE, rowRoute[i]);
      regWr(IDX_SRCSEL, {6'h00, rowSrc[i]});
      for (int p = 0; p < 2; p++) begin
        @(posedge clk_sys);
        internalOscillator <= p[0];
        extClockIn <= ~p[0];
        repeat (6) @(posedge clk_sys);
        outChk(rowMode[i] == 2 ? p[0] : rowMode[i] == 3 ? ~p[0] : rowMode[i][0],
               "route");
      end
    end
    internalOscillator <= 1'b0;
    $display("test routes done");

    regWr(IDX_ROUTE, 8'h00);
    regWr(IDX_SRCSEL, {6'h00, SRC_OSC});
    for (int i = 0; i < 4; i++) begin
      syncIn <= 1'b1;
      regWr(IDX_PHASE, divSet[i]);
      repeat (6) @(posedge clk_sys);
      outChk(divSet[i][BIT_START], "start level");
      syncIn <= 1'b0;
      repeat (6) @(posedge clk_sys);
      for (int e = 0; e <= int'(divSet[i][3:0]); e++) begin
        oscPulse();
        outChk(divSet[i][BIT_START] ^ (e == int'(divSet[i][3:0])),
               "phase delay");
      end
    end
    $display("test divider done");
    test_done();
  end
endmodule : output_divider_phase_route_cfg_tb

`default_nettype wire
